// [rtl/sync_clock_prescaler.sv]
// Purpose: shared power-of-two prescaler making processor, high-speed bus and peripheral bus clock enables
// Assumes: core_clk is the root clock; rst_b synchronous active low; one AHB-Lite master
// Notes: a domain's clock is core_clk qualified by its enable; enables and gates are registered
// Behaviour
// - root clock feeds one shared 8-bit prescaler for all synchronous clocks
// - processor and each peripheral bus clock pick any prescaler tap or the undivided root clock
// - processor clock is root frequency divided by two to the processor exponent
// - each peripheral bus clock divides by its own select register exponent
// - after reset every synchronous clock runs undivided
// - high-speed bus clock matches processor clock and may run while it is off
// - peripheral bus clocks stay synchronous, may divide further, run with processor stopped
// - individual clock gate per module on bus clocks
// - select writes apply to all clocks together; unchanged clocks keep frequency
// - clock ready flag reads zero from select write until setting applies
// - with ready interrupt enabled, interrupt raised when new setting is effective
// - after power-on the cause register shows the source; all domains running
// - root clock source started and calibrated before processor runs
// - the unit is always enabled and cannot be reset by software
// - once its own bus clock is gated off, only reset restores it
// - power-on detector holds system reset until supply is stable
// - debug halt keeps operation; in sleep under debug clocks keep running
// - writable registers optionally protected, except flag and reset cause registers
// - protection never blocks external debugger accesses
// - division ratios from 1x up to 128x
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module sync_clock_prescaler (
	input wire logic core_clk,
	input wire logic rst_b,
	input pm_clk_pkg::ahb_req_type ahb_req,
	output pm_clk_pkg::ahb_rsp_type ahb_rsp,
	input wire logic dbg_access,
	input wire logic wprot_lock,
	input wire logic supply_ok,
	input wire logic src_ready,
	input wire logic [pm_clk_pkg::CAUSE_W-1:0] rst_src,
	input wire logic sleep_req,
	input wire logic dbg_attach,
	output pm_clk_pkg::clk_en_type clk_en,
	output logic [pm_clk_pkg::MASK_W-1:0] ahb_gate,
	output logic [pm_clk_pkg::NUM_PBUS-1:0][pm_clk_pkg::MASK_W-1:0] pbus_gate,
	output logic irq,
	output logic sys_rst_b,
	output logic cpu_run
);
	pm_clk_pkg::pm_state_type st_r;
	pm_clk_pkg::pm_state_type st_nxt;
	logic tick_cpu;
	logic [pm_clk_pkg::NUM_PBUS-1:0] tick_pbus;
	logic apply;
	logic slp;
	logic bus_ok;
	logic wr_ok;
	logic sel_wr;
	logic flag_clr;
	logic [31:0] rd_val;

	// a tap of exponent e fires when the low e prescaler bits are all ones
	function automatic logic tap_tick(input logic [pm_clk_pkg::PRESC_W-1:0] presc,
		input logic [pm_clk_pkg::EXP_W-1:0] e);
		logic [pm_clk_pkg::PRESC_W-1:0] low;
		low = (pm_clk_pkg::PRESC_ONE << e) - pm_clk_pkg::PRESC_ONE;
		return (presc & low) == low;
	endfunction

	function automatic logic [pm_clk_pkg::OFS_W-1:0] reg_ofs(input logic [pm_clk_pkg::OFS_W-1:0] base,
		input int i);
		return pm_clk_pkg::OFS_W'(base + pm_clk_pkg::REG_STEP * pm_clk_pkg::OFS_W'(i));
	endfunction

	always_comb begin
		st_nxt = st_r;
		rd_val = '0;
		sel_wr = 1'b0;
		flag_clr = 1'b0;
		st_nxt.presc = st_r.presc + pm_clk_pkg::PRESC_ONE;
		tick_cpu = tap_tick(st_r.presc, st_r.cpu_exp);
		for (int i = 0; i < pm_clk_pkg::NUM_PBUS; i++) begin
			tick_pbus[i] = tap_tick(st_r.presc, st_r.pbus_exp[i]);
		end
		apply = st_r.pending && (st_r.presc[pm_clk_pkg::APPLY_W-1:0] == pm_clk_pkg::APPLY_PHASE);
		bus_ok = st_r.pbus_mask[0][pm_clk_pkg::PM_CLK_BIT];
		wr_ok = !wprot_lock || st_r.dp_dbg;

		// read view, built in the wait cycle so earlier writes are visible
		if (bus_ok) begin
			if (st_r.dp_addr == pm_clk_pkg::SLEEP_CFG_OFS) begin
				rd_val = 32'(st_r.sleep_lvl);
			end
			if (st_r.dp_addr == pm_clk_pkg::PROC_SEL_OFS) begin
				rd_val = 32'(st_r.pend_cpu_exp);
			end
			if (st_r.dp_addr == pm_clk_pkg::AHB_MASK_OFS) begin
				rd_val = st_r.ahb_mask;
			end
			if (st_r.dp_addr == pm_clk_pkg::INT_EN_CLR_OFS || st_r.dp_addr == pm_clk_pkg::INT_EN_SET_OFS) begin
				rd_val = 32'(st_r.inten);
			end
			if (st_r.dp_addr == pm_clk_pkg::INT_FLAG_OFS) begin
				rd_val = 32'(st_r.clock_ready_flag);
			end
			if (st_r.dp_addr == pm_clk_pkg::RESET_CAUSE_OFS) begin
				rd_val = 32'(st_r.cause);
			end
			for (int i = 0; i < pm_clk_pkg::NUM_PBUS; i++) begin
				if (st_r.dp_addr == reg_ofs(pm_clk_pkg::PBUS_SEL_OFS, i)) begin
					rd_val = 32'(st_r.pend_pbus_exp[i]);
				end
				if (st_r.dp_addr == reg_ofs(pm_clk_pkg::PBUS_MASK_OFS, i)) begin
					rd_val = st_r.pbus_mask[i];
				end
			end
		end

		unique case (st_r.phase)
			pm_clk_pkg::BUS_IDLE: begin
			end
			pm_clk_pkg::BUS_WR: begin
				if (bus_ok) begin
					if (st_r.dp_addr == pm_clk_pkg::INT_FLAG_OFS) begin
						flag_clr = ahb_req.hwdata[pm_clk_pkg::CLOCK_READY_FLAG_BIT];
					end
					if (wr_ok) begin
						if (st_r.dp_addr == pm_clk_pkg::SLEEP_CFG_OFS) begin
							st_nxt.sleep_lvl = ahb_req.hwdata[pm_clk_pkg::LVL_W-1:0];
						end
						if (st_r.dp_addr == pm_clk_pkg::PROC_SEL_OFS) begin
							st_nxt.pend_cpu_exp = ahb_req.hwdata[pm_clk_pkg::EXP_W-1:0];
							sel_wr = 1'b1;
						end
						if (st_r.dp_addr == pm_clk_pkg::AHB_MASK_OFS) begin
							st_nxt.ahb_mask = ahb_req.hwdata;
						end
						if (st_r.dp_addr == pm_clk_pkg::INT_EN_CLR_OFS && ahb_req.hwdata[pm_clk_pkg::CLOCK_READY_FLAG_BIT]) begin
							st_nxt.inten = 1'b0;
						end
						if (st_r.dp_addr == pm_clk_pkg::INT_EN_SET_OFS && ahb_req.hwdata[pm_clk_pkg::CLOCK_READY_FLAG_BIT]) begin
							st_nxt.inten = 1'b1;
						end
						for (int i = 0; i < pm_clk_pkg::NUM_PBUS; i++) begin
							if (st_r.dp_addr == reg_ofs(pm_clk_pkg::PBUS_SEL_OFS, i)) begin
								st_nxt.pend_pbus_exp[i] = ahb_req.hwdata[pm_clk_pkg::EXP_W-1:0];
								sel_wr = 1'b1;
							end
							if (st_r.dp_addr == reg_ofs(pm_clk_pkg::PBUS_MASK_OFS, i)) begin
								st_nxt.pbus_mask[i] = ahb_req.hwdata;
							end
						end
					end
				end
			end
			pm_clk_pkg::BUS_RD_WAIT: begin
				st_nxt.rsp.hrdata = rd_val;
				st_nxt.rsp.hreadyout = 1'b1;
			end
		endcase

		st_nxt.phase = pm_clk_pkg::BUS_IDLE;
		if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
			st_nxt.dp_addr = ahb_req.haddr[pm_clk_pkg::OFS_W-1:0];
			st_nxt.dp_dbg = dbg_access;
			if (ahb_req.hwrite) begin
				st_nxt.phase = pm_clk_pkg::BUS_WR;
			end else begin
				st_nxt.phase = pm_clk_pkg::BUS_RD_WAIT;
				st_nxt.rsp.hreadyout = 1'b0;
			end
		end

		// flag clear, then hardware set wins, then a new select write forces zero
		if (flag_clr) begin
			st_nxt.clock_ready_flag = 1'b0;
		end
		if (apply) begin
			st_nxt.cpu_exp = st_r.pend_cpu_exp;
			st_nxt.pbus_exp = st_r.pend_pbus_exp;
			st_nxt.pending = 1'b0;
			st_nxt.clock_ready_flag = 1'b1;
		end
		if (sel_wr) begin
			st_nxt.pending = 1'b1;
			st_nxt.clock_ready_flag = 1'b0;
		end
		st_nxt.irq = st_nxt.clock_ready_flag && st_nxt.inten;

		if (!st_r.cause_done) begin
			st_nxt.cause = rst_src;
			st_nxt.cause_done = 1'b1;
		end
		st_nxt.sys_rst_b = supply_ok;
		st_nxt.cpu_run = st_r.sys_rst_b && (st_r.cpu_run || src_ready);

		slp = sleep_req && !dbg_attach;
		st_nxt.clk_en.cpu = tick_cpu && st_r.cpu_run && !slp;
		st_nxt.clk_en.ahb = tick_cpu && !(slp && st_r.sleep_lvl >= pm_clk_pkg::LVL_AHB_STOP);
		for (int i = 0; i < pm_clk_pkg::NUM_PBUS; i++) begin
			st_nxt.clk_en.pbus[i] = tick_pbus[i] && !(slp && st_r.sleep_lvl >= pm_clk_pkg::LVL_PBUS_STOP);
			st_nxt.pbus_gate[i] = st_nxt.clk_en.pbus[i] ? st_r.pbus_mask[i] : '0;
		end
		st_nxt.ahb_gate = st_nxt.clk_en.ahb ? st_r.ahb_mask : '0;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			st_r <= '0;
			st_r.presc <= pm_clk_pkg::PRESC_RESET;
			st_r.cpu_exp <= pm_clk_pkg::EXP_UNDIVIDED;
			st_r.pbus_exp <= '0;
			st_r.pend_cpu_exp <= pm_clk_pkg::EXP_UNDIVIDED;
			st_r.pend_pbus_exp <= '0;
			st_r.clock_ready_flag <= 1'b1;
			st_r.ahb_mask <= pm_clk_pkg::AHB_MASK_RESET;
			st_r.pbus_mask <= {pm_clk_pkg::NUM_PBUS{pm_clk_pkg::PBUS_MASK_RESET}};
			st_r.phase <= pm_clk_pkg::BUS_IDLE;
			st_r.rsp.hreadyout <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ahb_rsp = st_r.rsp;
	assign clk_en = st_r.clk_en;
	assign ahb_gate = st_r.ahb_gate;
	assign pbus_gate = st_r.pbus_gate;
	assign irq = st_r.irq;
	assign sys_rst_b = st_r.sys_rst_b;
	assign cpu_run = st_r.cpu_run;

	a_ready_low_pending: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.pending |-> !st_r.clock_ready_flag) else $error("clock ready high while a setting is pending");
	a_apply_common_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(st_r.pending) && !$past(st_r.clock_ready_flag)
		|-> $past(st_r.presc[pm_clk_pkg::APPLY_W-1:0]) == pm_clk_pkg::APPLY_PHASE)
		else $error("divider change applied off the common edge");
	a_irq_on_ready: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(st_r.clock_ready_flag) && st_r.inten |-> irq) else $error("ready interrupt missing");
	a_cpu_undivided_run: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.cpu_exp == pm_clk_pkg::EXP_UNDIVIDED && st_r.cpu_run && !sleep_req ##1 st_r.cpu_run |-> clk_en.cpu)
		else $error("undivided processor clock skipped a cycle");
	a_ahb_with_cpu: assert property (@(posedge core_clk) disable iff (!rst_b)
		clk_en.cpu |-> clk_en.ahb) else $error("bus clock missing beside processor clock");
	a_pm_clock_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
		!st_r.pbus_mask[0][pm_clk_pkg::PM_CLK_BIT] |=> !st_r.pbus_mask[0][pm_clk_pkg::PM_CLK_BIT])
		else $error("own bus clock restored without reset");
	a_cpu_waits_source: assert property (@(posedge core_clk) disable iff (!rst_b)
		!cpu_run |-> !clk_en.cpu) else $error("processor clocked before source ready");
	a_por_holds_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
		!supply_ok |=> !sys_rst_b ##1 !cpu_run) else $error("system released with supply unstable");
	a_debug_sleep_clocks: assert property (@(posedge core_clk) disable iff (!rst_b)
		dbg_attach && tick_pbus[0] |=> clk_en.pbus[0]) else $error("clock stopped under debug");
	a_reset_undivided: assert property (@(posedge core_clk)
		!rst_b |=> st_r.cpu_exp == pm_clk_pkg::EXP_UNDIVIDED && st_r.pbus_exp == '0)
		else $error("reset left a divider set");

	// prescaler and taps
	a_presc_counts: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> st_r.presc == pm_clk_pkg::PRESC_W'($past(st_r.presc) + pm_clk_pkg::PRESC_ONE))
		else $error("prescaler did not count by one");
	a_unit_enabled: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) |-> st_r.presc != $past(st_r.presc))
		else $error("prescaler stalled");
	a_cpu_tap_select: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.cpu_run && !sleep_req |=> clk_en.cpu == $past(tick_cpu))
		else $error("processor enable left its tap");
	a_pbus_tap_select: assert property (@(posedge core_clk) disable iff (!rst_b)
		!sleep_req |=> clk_en.pbus == $past(tick_pbus))
		else $error("peripheral enable left its tap");
	a_undivided_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.cpu_exp == pm_clk_pkg::EXP_UNDIVIDED |-> tick_cpu)
		else $error("undivided tap skipped a cycle");
	a_cpu_tap_max: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.cpu_exp == '1 && tick_cpu |-> st_r.presc[pm_clk_pkg::APPLY_W-1:0] == pm_clk_pkg::APPLY_PHASE)
		else $error("largest processor ratio ticked early");
	a_pbus_tap_max: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.pbus_exp[0] == '1 && tick_pbus[0] |-> st_r.presc[pm_clk_pkg::APPLY_W-1:0] == pm_clk_pkg::APPLY_PHASE)
		else $error("largest peripheral ratio ticked early");

	// domains in sleep
	a_ahb_tracks_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
		!sleep_req |=> clk_en.ahb == $past(tick_cpu))
		else $error("bus clock off the processor tap");
	a_ahb_runs_cpu_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		sleep_req && st_r.sleep_lvl == '0 |=> clk_en.ahb == $past(tick_cpu))
		else $error("bus clock stopped with the processor");
	a_pbus_cpu_stopped: assert property (@(posedge core_clk) disable iff (!rst_b)
		sleep_req && st_r.sleep_lvl < pm_clk_pkg::LVL_PBUS_STOP |=> clk_en.pbus == $past(tick_pbus))
		else $error("peripheral clock stopped with the processor");
	a_cpu_stops_sleep: assert property (@(posedge core_clk) disable iff (!rst_b)
		sleep_req && !dbg_attach |=> !clk_en.cpu)
		else $error("processor clocked in sleep");

	// module gates
	a_ahb_gate_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
		ahb_gate == (clk_en.ahb ? $past(st_r.ahb_mask) : '0))
		else $error("bus module gate wrong");
	a_pbus_gate_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		pbus_gate[0] == (clk_en.pbus[0] ? $past(st_r.pbus_mask[0]) : '0))
		else $error("peripheral module gate wrong");
	a_pbus_gate_high: assert property (@(posedge core_clk) disable iff (!rst_b)
		pbus_gate[2] == (clk_en.pbus[2] ? $past(st_r.pbus_mask[2]) : '0))
		else $error("peripheral module gate wrong");

	// setting changes
	a_apply_together: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(apply) |-> st_r.cpu_exp == $past(st_r.pend_cpu_exp) && st_r.pbus_exp == $past(st_r.pend_pbus_exp))
		else $error("settings not applied together");
	a_exp_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) && !$past(apply) |-> $stable(st_r.cpu_exp) && $stable(st_r.pbus_exp))
		else $error("divider changed outside an apply");
	a_exp_change_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) && $changed(st_r.cpu_exp)
		|-> $past(st_r.presc[pm_clk_pkg::APPLY_W-1:0]) == pm_clk_pkg::APPLY_PHASE)
		else $error("processor divider changed off the common edge");
	a_tap_aligned: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(apply) && st_r.cpu_exp != pm_clk_pkg::EXP_UNDIVIDED |-> !tick_cpu)
		else $error("short pulse right after a change");
	a_ready_after_apply: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(apply) && !$past(sel_wr) |-> st_r.clock_ready_flag)
		else $error("clock ready not set on apply");
	a_ready_low_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(sel_wr) |-> !st_r.clock_ready_flag && st_r.pending)
		else $error("clock ready high after a select write");
	a_irq_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(st_r.clock_ready_flag) |-> !irq)
		else $error("interrupt held with ready low");

	// reset, start-up and cause
	a_cause_captured: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(st_r.cause_done) |-> st_r.cause == $past(rst_src))
		else $error("reset cause not captured");
	a_cause_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.cause_done && $past(st_r.cause_done) |-> $stable(st_r.cause))
		else $error("reset cause changed");
	a_active_after_reset: assert property (@(posedge core_clk)
		!rst_b |=> st_r.sleep_lvl == '0)
		else $error("reset left a sleep level");
	a_cpu_run_late: assert property (@(posedge core_clk) disable iff (!rst_b)
		!sys_rst_b |=> !cpu_run)
		else $error("processor released under system reset");
	a_src_gates_run: assert property (@(posedge core_clk) disable iff (!rst_b)
		!cpu_run && !src_ready |=> !cpu_run)
		else $error("processor released before source ready");
	a_reset_ready_set: assert property (@(posedge core_clk)
		!rst_b |=> st_r.clock_ready_flag && !st_r.pending)
		else $error("reset left a setting pending");
	a_reset_masks: assert property (@(posedge core_clk)
		!rst_b |=> st_r.ahb_mask == pm_clk_pkg::AHB_MASK_RESET && st_r.pbus_mask[0] == pm_clk_pkg::PBUS_MASK_RESET)
		else $error("reset left a module mask");

	// register access
	a_pm_writes_blocked: assert property (@(posedge core_clk) disable iff (!rst_b)
		!bus_ok && st_r.phase == pm_clk_pkg::BUS_WR |=> $stable(st_r.ahb_mask) && $stable(st_r.pbus_mask))
		else $error("mask written with own clock off");
	a_pm_read_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		!bus_ok && st_r.phase == pm_clk_pkg::BUS_RD_WAIT |=> ahb_rsp.hrdata == '0)
		else $error("register read with own clock off");
	a_protect_blocks: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.phase == pm_clk_pkg::BUS_WR && wprot_lock && !st_r.dp_dbg
		|=> $stable(st_r.sleep_lvl) && $stable(st_r.ahb_mask) && $stable(st_r.inten) && $stable(st_r.pend_cpu_exp))
		else $error("protected register written");
	a_flag_clear_open: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.phase == pm_clk_pkg::BUS_WR && bus_ok && st_r.dp_addr == pm_clk_pkg::INT_FLAG_OFS
		&& ahb_req.hwdata[pm_clk_pkg::CLOCK_READY_FLAG_BIT] && !apply |=> !st_r.clock_ready_flag)
		else $error("flag clear blocked");
	a_debug_write_open: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_r.phase == pm_clk_pkg::BUS_WR && bus_ok && st_r.dp_dbg && st_r.dp_addr == pm_clk_pkg::SLEEP_CFG_OFS
		|=> st_r.sleep_lvl == $past(ahb_req.hwdata[pm_clk_pkg::LVL_W-1:0]))
		else $error("debugger write blocked");

	// debug keeps clocks
	a_debug_all_run: assert property (@(posedge core_clk) disable iff (!rst_b)
		dbg_attach |=> clk_en.ahb == $past(tick_cpu) && clk_en.pbus == $past(tick_pbus))
		else $error("bus clock stopped under debug");
	a_debug_cpu_run: assert property (@(posedge core_clk) disable iff (!rst_b)
		dbg_attach && st_r.cpu_run |=> clk_en.cpu == $past(tick_cpu))
		else $error("processor clock stopped under debug");
endmodule

// [include/pm_clk_pkg.sv]
// Purpose: shared constants and types for the synchronous clock prescaler
// Assumes: one root clock, AHB-Lite register access, 32-bit data
// Notes: clock domains leave the block as one-cycle clock enables
package pm_clk_pkg;
	localparam int EXP_W = 3;
	localparam int PRESC_W = 8;
	localparam int APPLY_W = 7;
	localparam int NUM_PBUS = 3;
	localparam int MASK_W = 32;
	localparam int OFS_W = 8;
	localparam int LVL_W = 2;
	localparam int CAUSE_W = 8;

	localparam logic [PRESC_W-1:0] PRESC_ONE = 8'h01;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;
	// all taps up to 128x end their period together here
	localparam logic [APPLY_W-1:0] APPLY_PHASE = 7'h7f;
	localparam logic [EXP_W-1:0] EXP_UNDIVIDED = 3'h0;

	localparam logic [OFS_W-1:0] SLEEP_CFG_OFS = 8'h00;
	localparam logic [OFS_W-1:0] PROC_SEL_OFS = 8'h08;
	localparam logic [OFS_W-1:0] PBUS_SEL_OFS = 8'h0c;
	localparam logic [OFS_W-1:0] AHB_MASK_OFS = 8'h18;
	localparam logic [OFS_W-1:0] PBUS_MASK_OFS = 8'h1c;
	localparam logic [OFS_W-1:0] INT_EN_CLR_OFS = 8'h30;
	localparam logic [OFS_W-1:0] INT_EN_SET_OFS = 8'h34;
	localparam logic [OFS_W-1:0] INT_FLAG_OFS = 8'h38;
	localparam logic [OFS_W-1:0] RESET_CAUSE_OFS = 8'h3c;
	localparam logic [OFS_W-1:0] REG_STEP = 8'h04;

	localparam int CLOCK_READY_FLAG_BIT = 0;
	localparam int PM_CLK_BIT = 1;
	localparam logic [MASK_W-1:0] AHB_MASK_RESET = 32'hffffffff;
	localparam logic [MASK_W-1:0] PBUS_MASK_RESET = 32'h0000007f;
	localparam logic [LVL_W-1:0] LVL_AHB_STOP = 2'h1;
	localparam logic [LVL_W-1:0] LVL_PBUS_STOP = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_type;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} ahb_rsp_type;

	typedef struct packed {
		logic cpu;
		logic ahb;
		logic [NUM_PBUS-1:0] pbus;
	} clk_en_type;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT} bus_phase_type;

	typedef struct packed {
		logic [PRESC_W-1:0] presc;
		logic [EXP_W-1:0] cpu_exp;
		logic [NUM_PBUS-1:0][EXP_W-1:0] pbus_exp;
		logic [EXP_W-1:0] pend_cpu_exp;
		logic [NUM_PBUS-1:0][EXP_W-1:0] pend_pbus_exp;
		logic pending;
		logic clock_ready_flag;
		logic inten;
		logic irq;
		logic [LVL_W-1:0] sleep_lvl;
		logic [MASK_W-1:0] ahb_mask;
		logic [NUM_PBUS-1:0][MASK_W-1:0] pbus_mask;
		logic [CAUSE_W-1:0] cause;
		logic cause_done;
		logic sys_rst_b;
		logic cpu_run;
		bus_phase_type phase;
		logic [OFS_W-1:0] dp_addr;
		logic dp_dbg;
		ahb_rsp_type rsp;
		clk_en_type clk_en;
		logic [MASK_W-1:0] ahb_gate;
		logic [NUM_PBUS-1:0][MASK_W-1:0] pbus_gate;
	} pm_state_type;
endpackage

// [bench/clk_consumer_model.sv]
// Purpose: stand-in for the processor and bus peripherals that consume the clock enables
// Assumes: enables are one-cycle pulses of core_clk, level 1 when undivided
// Notes: period is the spacing of the last two pulses in root cycles
`timescale 1ns/100ps
module clk_consumer_model (
	input wire logic core_clk,
	input pm_clk_pkg::clk_en_type clk_en,
	output int period [5]
);
	int cnt [5];
	always @(posedge core_clk) begin
		for (int i = 0; i < 5; i++) begin
			if (clk_en[i]) begin
				period[i] <= cnt[i] + 1;
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule

// [bench/test_sync_clock_prescaler.sv]
// Purpose: self-checking bench for the synchronous clock prescaler
// Assumes: single-word AHB-Lite master; hready is the slave's hreadyout
// Notes: divider settings come from an xorshift stream, with 128x and 1x corners
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_sync_clock_prescaler;
	logic core_clk = 0;
	logic rst_b = 0;
	pm_clk_pkg::ahb_req_type m = '0;
	pm_clk_pkg::ahb_req_type req;
	pm_clk_pkg::ahb_rsp_type rsp;
	logic dbg_access = 0, wprot_lock = 0, supply_ok = 0, src_ready = 0, sleep_req = 0, dbg_attach = 0;
	logic [7:0] rst_src = 8'h01;
	pm_clk_pkg::clk_en_type clk_en;
	logic [31:0] ahb_gate;
	logic [2:0][31:0] pbus_gate;
	logic irq, sys_rst_b, cpu_run;
	int period [5];
	int seen [5];
	int errors = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h00009f0d;
	logic [31:0] q;
	logic [31:0] amask = 32'hffffffff;
	logic [2:0] ce;
	logic [2:0] pb [3] = '{3'h0, 3'h0, 3'h0};
	always #12.5 core_clk = ~core_clk;
	always_comb begin
		req = m;
		req.hready = rsp.hreadyout;
	end
	sync_clock_prescaler i_sync_clock_prescaler (.core_clk(core_clk), .rst_b(rst_b), .ahb_req(req), .ahb_rsp(rsp),
		.dbg_access(dbg_access), .wprot_lock(wprot_lock), .supply_ok(supply_ok), .src_ready(src_ready),
		.rst_src(rst_src), .sleep_req(sleep_req), .dbg_attach(dbg_attach), .clk_en(clk_en), .ahb_gate(ahb_gate),
		.pbus_gate(pbus_gate), .irq(irq), .sys_rst_b(sys_rst_b), .cpu_run(cpu_run));
	clk_consumer_model i_clk_consumer_model (.core_clk(core_clk), .clk_en(clk_en), .period(period));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int per(logic [2:0] e);
		return 1 << e;
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_for(input int what, input int bound);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while ((what ? irq : rsp.hreadyout) !== 1'b1 && n < bound);
		if (n >= bound) begin
			errors++;
			$display("MISMATCH %0t wait ran out", $time);
			give_verdict();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		m.hsel <= 1'b1;
		m.haddr <= {24'h0, a};
		m.htrans <= 2'h2;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		wait_for(0, 50);
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= d;
		wait_for(0, 50);
		q = rsp.hrdata;
	endtask
	task automatic count_en();
		seen = '{default: 0};
		repeat (3) @(posedge core_clk);
		repeat (300) begin
			@(posedge core_clk);
			for (int i = 0; i < 5; i++) begin
				seen[i] += int'(clk_en[i]);
			end
			`CHK(ahb_gate, {32{clk_en.ahb}} & amask)
			`CHK(pbus_gate[2], {32{clk_en.pbus[2]}} & 32'h0000007f)
		end
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK(sys_rst_b, 1'b0)
		supply_ok <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK({sys_rst_b, cpu_run}, 2'h2)
		`CHK({clk_en.ahb, clk_en.pbus}, 4'hf)
		src_ready <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK(cpu_run, 1'b1)
		`CHK(clk_en, 5'h1f)
		bus(1'b0, pm_clk_pkg::RESET_CAUSE_OFS, 32'h0);
		`CHK(q, 32'h00000001)
		bus(1'b0, pm_clk_pkg::INT_FLAG_OFS, 32'h0);
		`CHK(q[0], 1'b1)
		$display("test reset done");
		bus(1'b1, pm_clk_pkg::INT_EN_SET_OFS, 32'h1);
		for (int k = 0; k < 6; k++) begin
			ce = (k == 0) ? 3'h7 : (k == 1) ? 3'h0 : 3'(xs());
			// an unchanged write lines the writes up just after an apply edge
			bus(1'b1, pm_clk_pkg::PBUS_SEL_OFS, 32'(pb[0]));
			repeat (2) @(posedge core_clk);
			wait_for(1, 300);
			bus(1'b1, pm_clk_pkg::PROC_SEL_OFS, 32'(ce));
			for (int i = 0; i < 3; i++) begin
				pb[i] = 3'(ce + xs() % (8 - ce));
				bus(1'b1, 8'(pm_clk_pkg::PBUS_SEL_OFS + pm_clk_pkg::REG_STEP * i), 32'(pb[i]));
			end
			`CHK(irq, 1'b0)
			wait_for(1, 300);
			bus(1'b0, pm_clk_pkg::INT_FLAG_OFS, 32'h0);
			`CHK(q[0], 1'b1)
			repeat (300) @(posedge core_clk);
			`CHK(period[4], per(ce))
			`CHK(period[3], per(ce))
			for (int i = 0; i < 3; i++) begin
				`CHK(period[i], per(pb[i]))
			end
		end
		bus(1'b1, pm_clk_pkg::INT_EN_CLR_OFS, 32'h1);
		bus(1'b1, pm_clk_pkg::PROC_SEL_OFS, 32'h0);
		repeat (200) @(posedge core_clk);
		`CHK(irq, 1'b0)
		$display("test dividers done");
		wprot_lock <= 1'b1;
		bus(1'b1, pm_clk_pkg::INT_FLAG_OFS, 32'h1);
		bus(1'b0, pm_clk_pkg::INT_FLAG_OFS, 32'h0);
		`CHK(q[0], 1'b0)
		bus(1'b1, pm_clk_pkg::SLEEP_CFG_OFS, 32'h2);
		bus(1'b0, pm_clk_pkg::SLEEP_CFG_OFS, 32'h0);
		`CHK(q[1:0], 2'h0)
		dbg_access <= 1'b1;
		bus(1'b1, pm_clk_pkg::SLEEP_CFG_OFS, 32'h1);
		dbg_access <= 1'b0;
		bus(1'b0, pm_clk_pkg::SLEEP_CFG_OFS, 32'h0);
		`CHK(q[1:0], 2'h1)
		wprot_lock <= 1'b0;
		$display("test protect done");
		amask = xs();
		bus(1'b1, pm_clk_pkg::AHB_MASK_OFS, amask);
		sleep_req <= 1'b1;
		count_en();
		`CHK({seen[4] > 0, seen[3] > 0, seen[0] > 0}, 3'h1)
		dbg_attach <= 1'b1;
		count_en();
		`CHK({seen[4] > 0, seen[3] > 0, seen[0] > 0}, 3'h7)
		sleep_req <= 1'b0;
		dbg_attach <= 1'b0;
		$display("test sleep done");
		bus(1'b1, pm_clk_pkg::PBUS_MASK_OFS, 32'h0000007d);
		bus(1'b1, pm_clk_pkg::PBUS_MASK_OFS, 32'h0000007f);
		bus(1'b0, pm_clk_pkg::PBUS_MASK_OFS, 32'h0);
		`CHK(q, 32'h00000000)
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		bus(1'b0, pm_clk_pkg::PBUS_MASK_OFS, 32'h0);
		`CHK(q, 32'h0000007f)
		$display("test bus clock done");
		give_verdict();
	end
endmodule
